/* File: bench/ddc_partner.sv */
// Event sources on the far side: timers, line nine, underrun
`timescale 1ns/100ps

module ddc_partner (
   input wire logic clk,
   input wire logic fire,
   input wire logic [2:0] src,
   output logic [5:0] timer_trigger_out,
   output logic ext_line9,
   output logic ch1_underrun
);
   // One-cycle pulses; lines drop straight back so no stale level lingers
   always_ff @(posedge clk) begin
      timer_trigger_out <= (fire && src < 3'h6) ?
         6'h01 << src : 6'h00;
      ext_line9 <= fire && src == 3'h6;
      ch1_underrun <= fire && src == 3'h7;
   end
endmodule : ddc_partner

/* File: bench/ddc_top_props.sv */
// Port checker of the converter control block
`timescale 1ns/100ps
`include "ddc_params.svh"

module ddc_top_props
   import ddc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [5:0] timer_trigger_out,
   input wire logic ext_line9,
   input wire logic ch1_underrun,
   input wire logic ch1_on,
   input wire logic ch1_buffer_off,
   input wire logic ch2_on,
   input wire logic ch2_buffer_off,
   input wire logic ch1_dma_on,
   input wire logic ch1_dma_req,
   input wire logic ch1_underrun_irq,
   input wire ddc_sample_t ch1_output_value,
   input wire ddc_sample_t ch2_output_value
);
   logic [31:0] ctl_ff;
   logic bus_wr, ctl_wr, udr_on, sel_evt;
   ddc_sample_t wlo;

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   assign bus_wr = psel && penable && pwrite;
   assign ctl_wr = bus_wr && paddr == `DDC_OFS_CTRL;
   assign wlo = pwdata[11:0];
   assign udr_on = ch1_underrun && ctl_ff[`DDC_CH1_UDRIE_BIT];
   // Soft source is no line, so it never counts as an event here
   assign sel_evt = ctl_ff[2] && ctl_ff[5:3] != `DDC_TSEL_SOFT &&
      (ctl_ff[5:3] == `DDC_TSEL_EXT9 ? ext_line9 :
      timer_trigger_out[ctl_ff[5:3]]);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctl_ff <= '0;
      end else if (ctl_wr) begin
         ctl_ff <= pwdata;
      end
   end

   sequence dma_after_load;
      (!ch1_dma_req) [*2] ##1 ch1_dma_req;
   endsequence

   a_ch1_enable: assert property (ctl_wr |=> ch1_on == ctl_ff[0])
      else $error("ch1_on differs from control");
   a_ch1_buffer: assert property (
      ctl_wr |=> ch1_buffer_off == ctl_ff[1])
      else $error("ch1_buffer_off differs from control");
   a_ch2_enable: assert property (ctl_wr |=> ch2_on == ctl_ff[16])
      else $error("ch2_on differs from control");
   a_ch2_buffer: assert property (
      ctl_wr |=> ch2_buffer_off == ctl_ff[17])
      else $error("ch2_buffer_off differs from control");
   a_dma_mode: assert property (
      ctl_wr |=> ch1_dma_on == ctl_ff[12])
      else $error("ch1_dma_on differs from control");
   a_ctrl_hold: assert property (
      !ctl_wr |=> $stable({ch2_buffer_off, ch2_on, ch1_dma_on,
      ch1_buffer_off, ch1_on}))
      else $error("control outputs moved without a write");
   a_irq_gate: assert property (ch1_underrun_irq == $past(udr_on))
      else $error("underrun interrupt not gated");
   a_direct_load: assert property (
      bus_wr && paddr == `DDC_OFS_CH1_R12 && !ctl_ff[2]
      |=> ##1 ch1_output_value == $past(wlo, 2))
      else $error("ch1 output not loaded one cycle after write");
   a_ch2_load: assert property (bus_wr && paddr == `DDC_OFS_CH2_R12
      |=> ##1 ch2_output_value == $past(wlo, 2))
      else $error("ch2 output not loaded one cycle after write");
   a_trig_delay: assert property (sel_evt && ctl_ff[12]
      |-> ##1 dma_after_load)
      else $error("triggered load not three cycles after event");
   a_dma_quiet: assert property (
      (!ch1_dma_on) [*3] |-> !ch1_dma_req)
      else $error("dma request while dma mode off");
endmodule : ddc_top_props

bind ddc_top ddc_top_props u_props (.clk, .reset_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_trigger_out, .ext_line9,
   .ch1_underrun, .ch1_on, .ch1_buffer_off, .ch2_on, .ch2_buffer_off,
   .ch1_dma_on, .ch1_dma_req, .ch1_underrun_irq, .ch1_output_value,
   .ch2_output_value);

/* File: bench/ddc_top_tb.sv */
// Self-checking bench of the converter control block
`timescale 1ns/100ps
`include "ddc_params.svh"

module ddc_top_tb
   import ddc_pkg::*;
   ();
   typedef struct {string name; logic [31:0] val;} ddc_note_s;
   ddc_note_s notes[$];
   logic clk, reset_n, psel, penable, pwrite, fire, pready, pslverr;
   logic ext_line9, ch1_underrun, ch1_on, ch1_buffer_off, ch2_on;
   logic ch2_buffer_off, ch1_dma_on, ch1_dma_req, ch1_underrun_irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [2:0] src;
   logic [5:0] timer_trigger_out;
   ddc_sample_t ch1_output_value, ch2_output_value, v, lfsr;
   logic [7:0] ofs[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h2c,
      8'h30, 8'h40};
   ddc_sample_t tri_off[8] = '{0, 1, 2, 3, 2, 1, 0, 1};
   int num_errors, num_checks, i;

   ddc_top uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .timer_trigger_out, .ext_line9,
      .ch1_underrun, .ch1_on, .ch1_buffer_off, .ch2_on, .ch2_buffer_off,
      .ch1_dma_on, .ch1_dma_req, .ch1_underrun_irq, .ch1_output_value,
      .ch2_output_value);
   ddc_partner u_src (.clk, .fire, .src, .timer_trigger_out, .ext_line9,
      .ch1_underrun);

   // ************
   // Bus and event tasks
   // ************
   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Leaves the bus in its access phase; the next call's edge completes it
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input string name);
      @(posedge clk);
      #1;
      psel = 1'b1;
      penable = 1'b0;
      pwrite = wr;
      paddr = a;
      pwdata = wr ? d : $urandom;
      if (!wr) notes.push_back('{name, d});
      @(posedge clk);
      #1;
      penable = 1'b1;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, "");
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input string n);
      bus(1'b0, a, e, n);
   endtask : rd

   task automatic idle(input int n);
      @(posedge clk);
      #1;
      psel = 1'b0;
      penable = 1'b0;
      repeat (n) @(posedge clk);
   endtask : idle

   task automatic pulse(input logic [2:0] s);
      idle(0);
      fire = 1'b1;
      src = s;
      @(posedge clk);
      #1;
      fire = 1'b0;
      repeat (6) @(posedge clk);
   endtask : pulse

   task automatic conclude();
      if (num_errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude

   always @(posedge clk) begin
      if (psel && penable && !pwrite) begin
         check(notes[0].name, prdata, notes[0].val);
         void'(notes.pop_front());
      end
   end

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Run needs well under a thousand cycles; this allows many times that
   initial begin
      #200000;
      num_errors++;
      conclude();
   end

   initial begin
      {reset_n, psel, penable, pwrite, fire, paddr, pwdata, src} = '0;
      void'($urandom(98242));
      repeat (16) @(posedge clk);
      #1;
      reset_n = 1'b1;
      wr(8'h40, $urandom);
      foreach (ofs[j]) rd(ofs[j], 32'h0, "reset or unmapped");
      r = $urandom;
      wr(8'h00, r);
      rd(8'h00, r & `DDC_CTRL_WMASK, "control");
      wr(8'h00, 32'h0);
      for (i = 0; i < 3; i++) begin
         r = $urandom;
         wr(8'h08 + 8'(4 * i), r);
         v = i == 0 ? r[11:0] : i == 1 ? r[15:4] : {r[7:0], 4'h0};
         rd(8'h08, {20'h0, v}, "hold right12");
         rd(8'h0c, {16'h0, v, 4'h0}, "hold left12");
         rd(8'h10, {24'h0, v[11:4]}, "hold right8");
         rd(8'h2c, {20'h0, v}, "ch1 output");
      end
      r = $urandom;
      wr(8'h14, r);
      wr(8'h30, ~r);
      wr(8'h2c, ~r);
      rd(8'h14, {20'h0, r[11:0]}, "ch2 hold");
      rd(8'h30, {20'h0, r[11:0]}, "ch2 output");
      rd(8'h2c, {20'h0, v}, "ch1 output");
      wr(8'h04, 32'h2);
      rd(8'h04, 32'h2, "fire two set");
      rd(8'h04, 32'h0, "fire two clear");
      wr(8'h00, 32'h3c);
      r = $urandom;
      wr(8'h08, r);
      rd(8'h2c, {20'h0, v}, "ch1 held");
      wr(8'h04, 32'h1);
      rd(8'h2c, {20'h0, r[11:0]}, "ch1 soft load");
      rd(8'h04, 32'h0, "fire one clear");
      v = r[11:0];
      for (i = 0; i < 7; i++) begin
         wr(8'h00, 32'h1004 | (32'(i) << 3) | (32'(i) << 13));
         r = $urandom;
         wr(8'h08, r);
         pulse(3'h7);
         pulse(3'((i + 1) % 7));
         rd(8'h2c, {20'h0, v}, "wrong source");
         pulse(3'(i));
         rd(8'h2c, {20'h0, r[11:0]}, "triggered");
         v = r[11:0];
      end
      idle(0);
      reset_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      reset_n = 1'b1;
      wr(8'h00, 32'h184);
      r = $urandom;
      wr(8'h08, r);
      foreach (tri_off[j]) begin
         pulse(3'h0);
         rd(8'h2c, {20'h0, r[11:0] + tri_off[j]}, "triangle");
      end
      // Noise with an eight-bit mask; generator restarted from its seed
      wr(8'h00, 32'h744);
      lfsr = `DDC_LFSR_SEED;
      repeat (4) begin
         pulse(3'h0);
         rd(8'h2c, {20'h0, r[11:0] + (lfsr & 12'h0ff)}, "noise");
         lfsr = {lfsr[10:0], lfsr[11] ^ lfsr[5] ^ lfsr[3] ^ lfsr[0]};
      end
      idle(4);
      conclude();
   end
endmodule : ddc_top_tb

/* File: hw/ddc_params.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

// ******************************************************
// Register offsets (byte addresses)
// ******************************************************
`define DDC_OFS_CTRL 8'h00
`define DDC_OFS_SWTRIG 8'h04
`define DDC_OFS_CH1_R12 8'h08
`define DDC_OFS_CH1_L12 8'h0c
`define DDC_OFS_CH1_R8 8'h10
`define DDC_OFS_CH2_R12 8'h14
`define DDC_OFS_CH1_OUT 8'h2c
`define DDC_OFS_CH2_OUT 8'h30

// ******************************************************
// Control register fields
// ******************************************************
`define DDC_CH1_ON_BIT 0
`define DDC_CH1_BUF_OFF_BIT 1
`define DDC_CH1_TRIG_ON_BIT 2
`define DDC_CH1_TSEL_LSB 3
`define DDC_CH1_TSEL_MSB 5
`define DDC_CH1_WAVE_LSB 6
`define DDC_CH1_WAVE_MSB 7
`define DDC_CH1_MAMP_LSB 8
`define DDC_CH1_MAMP_MSB 11
`define DDC_CH1_DMA_BIT 12
`define DDC_CH1_UDRIE_BIT 13
`define DDC_CH2_ON_BIT 16
`define DDC_CH2_BUF_OFF_BIT 17
`define DDC_CTRL_WMASK 32'h00033fff

// ******************************************************
// Software trigger register fields
// ******************************************************
`define DDC_SW_CH1_BIT 0
`define DDC_SW_CH2_BIT 1

// ******************************************************
// Codes, reset values and timing
// ******************************************************
`define DDC_TSEL_EXT9 3'h6
`define DDC_TSEL_SOFT 3'h7
`define DDC_MAMP_FULL 4'hb
`define DDC_RESET_WORD 32'h00000000
`define DDC_LFSR_SEED 12'haaa
`define DDC_TRIG_CYCLES 3

`endif

/* File: hw/ddc_pkg.sv */
// Types and shared helpers for the dual converter control block
`include "ddc_params.svh"

package ddc_pkg;

   typedef logic [11:0] ddc_sample_t;

   // Delay pipeline for hardware-triggered channel-one transfers
   typedef enum logic [1:0] {
      XFER_IDLE,
      XFER_WAIT1,
      XFER_WAIT2
   } ddc_xfer_e;

   // Mask of n+1 low ones; codes at or above full select all bits
   function automatic ddc_sample_t ddc_mask(input logic [3:0] code);
      ddc_sample_t m;
      m = 12'hfff;
      if (code < `DDC_MAMP_FULL) begin
         m = ddc_sample_t'((13'h0002 << code) - 13'h0001);
      end
      return m;
   endfunction : ddc_mask

endpackage : ddc_pkg

/* File: hw/ddc_top.sv */
// Control and data-holding logic of the two-channel converter
`timescale 1ns/100ps

module ddc_top
   import ddc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] timer_trigger_out,
   input wire logic ext_line9,
   input wire logic ch1_underrun,
   output logic ch1_on,
   output logic ch1_buffer_off,
   output logic ch2_on,
   output logic ch2_buffer_off,
   output logic ch1_dma_on,
   output logic ch1_dma_req,
   output logic ch1_underrun_irq,
   output ddc_sample_t ch1_output_value,
   output ddc_sample_t ch2_output_value
);

   // ******************************************************
   // Declarations
   // ******************************************************
   logic [31:0] ctrl_ff;
   logic [1:0] soft_fire_ff;
   logic [1:0] nxt_soft_fire;
   ddc_sample_t ch1_hold_value_ff;
   ddc_sample_t ch2_hold_value_ff;
   ddc_sample_t ch1_out_ff;
   ddc_sample_t ch2_out_ff;
   ddc_xfer_e xfer_ff;
   ddc_xfer_e nxt_xfer;
   logic ch1_pend_ff;
   logic ch2_pend_ff;
   logic ch1_clr_ff;
   logic ch2_clr_ff;
   logic dma_req_ff;
   logic irq_ff;
   logic wr_en;
   logic wr_ch1;
   logic ch1_trigger_on;
   logic [2:0] ch1_trigger_source;
   logic [1:0] ch1_wave_select;
   logic [3:0] ch1_mask_amplitude;
   logic hw_event;
   logic soft_go1;
   logic soft_go2;
   logic load1;
   logic load2;
   logic trig_load1;
   ddc_sample_t wave_offset;

   // ******************************************************
   // Bus decode
   // ******************************************************
   // Byte lanes are not decoded: only word accesses are legal
   assign wr_en = psel && penable && pwrite;
   assign wr_ch1 = wr_en && (paddr == `DDC_OFS_CH1_R12 ||
                             paddr == `DDC_OFS_CH1_L12 ||
                             paddr == `DDC_OFS_CH1_R8);
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // ******************************************************
   // Control fields
   // ******************************************************
   assign ch1_on = ctrl_ff[`DDC_CH1_ON_BIT];
   assign ch1_buffer_off = ctrl_ff[`DDC_CH1_BUF_OFF_BIT];
   assign ch2_on = ctrl_ff[`DDC_CH2_ON_BIT];
   assign ch2_buffer_off = ctrl_ff[`DDC_CH2_BUF_OFF_BIT];
   assign ch1_dma_on = ctrl_ff[`DDC_CH1_DMA_BIT];
   assign ch1_trigger_on = ctrl_ff[`DDC_CH1_TRIG_ON_BIT];
   assign ch1_trigger_source =
      ctrl_ff[`DDC_CH1_TSEL_MSB:`DDC_CH1_TSEL_LSB];
   assign ch1_wave_select = ctrl_ff[`DDC_CH1_WAVE_MSB:`DDC_CH1_WAVE_LSB];
   assign ch1_mask_amplitude =
      ctrl_ff[`DDC_CH1_MAMP_MSB:`DDC_CH1_MAMP_LSB];
   assign ch1_dma_req = dma_req_ff;
   assign ch1_underrun_irq = irq_ff;
   assign ch1_output_value = ch1_out_ff;
   assign ch2_output_value = ch2_out_ff;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_ff <= `DDC_RESET_WORD;
      end else if (wr_en && paddr == `DDC_OFS_CTRL) begin
         ctrl_ff <= pwdata & `DDC_CTRL_WMASK;
      end
   end

   // ******************************************************
   // Holding values
   // ******************************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ch1_hold_value_ff <= 12'h000;
      end else if (wr_ch1) begin
         // Last write of any format wins
         unique case (paddr)
            `DDC_OFS_CH1_R12: ch1_hold_value_ff <= pwdata[11:0];
            `DDC_OFS_CH1_L12: ch1_hold_value_ff <= pwdata[15:4];
            default: ch1_hold_value_ff <= {pwdata[7:0], 4'h0};
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ch2_hold_value_ff <= 12'h000;
      end else if (wr_en && paddr == `DDC_OFS_CH2_R12) begin
         ch2_hold_value_ff <= pwdata[11:0];
      end
   end

   // ******************************************************
   // Software trigger register
   // ******************************************************
   // A new fire written in the clearing cycle survives the clear
   always_comb begin
      nxt_soft_fire = soft_fire_ff;
      if (ch1_clr_ff) begin
         nxt_soft_fire[`DDC_SW_CH1_BIT] = 1'b0;
      end
      if (ch2_clr_ff) begin
         nxt_soft_fire[`DDC_SW_CH2_BIT] = 1'b0;
      end
      if (wr_en && paddr == `DDC_OFS_SWTRIG) begin
         nxt_soft_fire = nxt_soft_fire | pwdata[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         soft_fire_ff <= 2'b00;
      end else begin
         soft_fire_ff <= nxt_soft_fire;
      end
   end

   // ******************************************************
   // Channel-one trigger selection and delay
   // ******************************************************
   always_comb begin
      unique case (ch1_trigger_source)
         `DDC_TSEL_EXT9: hw_event = ext_line9;
         `DDC_TSEL_SOFT: hw_event = 1'b0;
         default: hw_event = timer_trigger_out[ch1_trigger_source];
      endcase
   end

   // Events arriving during a pending transfer are dropped
   always_comb begin
      nxt_xfer = xfer_ff;
      unique case (xfer_ff)
         XFER_IDLE: begin
            if (ch1_trigger_on && hw_event) begin
               nxt_xfer = XFER_WAIT1;
            end
         end
         XFER_WAIT1: nxt_xfer = XFER_WAIT2;
         XFER_WAIT2: nxt_xfer = XFER_IDLE;
         // Fourth code is never entered; fall back to idle if upset
         default: nxt_xfer = XFER_IDLE;
      endcase
      if (!ch1_trigger_on) begin
         nxt_xfer = XFER_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         xfer_ff <= XFER_IDLE;
      end else begin
         xfer_ff <= nxt_xfer;
      end
   end

   // Masking the fire bit until its clear stops a second load
   assign soft_go1 = ch1_trigger_on &&
                     ch1_trigger_source == `DDC_TSEL_SOFT &&
                     soft_fire_ff[`DDC_SW_CH1_BIT] && !ch1_clr_ff;
   assign trig_load1 = (xfer_ff == XFER_WAIT2 && ch1_trigger_on) || soft_go1;
   assign load1 = (ch1_pend_ff && !ch1_trigger_on) || trig_load1;
   assign soft_go2 = soft_fire_ff[`DDC_SW_CH2_BIT] && !ch2_clr_ff;
   assign load2 = ch2_pend_ff || soft_go2;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ch1_pend_ff <= 1'b0;
         ch2_pend_ff <= 1'b0;
      end else begin
         ch1_pend_ff <= wr_ch1;
         ch2_pend_ff <= wr_en && paddr == `DDC_OFS_CH2_R12;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ch1_clr_ff <= 1'b0;
         ch2_clr_ff <= 1'b0;
      end else begin
         ch1_clr_ff <= soft_go1;
         ch2_clr_ff <= soft_go2;
      end
   end

   // ******************************************************
   // Output registers
   // ******************************************************
   ddc_wave_gen u_wave (
      .clk(clk),
      .reset_n(reset_n),
      .wave_select(ch1_trigger_on ? ch1_wave_select : 2'b00),
      .mask_amplitude(ch1_mask_amplitude),
      .step(trig_load1),
      .offset(wave_offset)
   );

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ch1_out_ff <= 12'h000;
      end else if (load1) begin
         // Sum wraps at twelve bits; no saturation is applied
         ch1_out_ff <= ch1_hold_value_ff + wave_offset;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ch2_out_ff <= 12'h000;
      end else if (load2) begin
         ch2_out_ff <= ch2_hold_value_ff;
      end
   end

   // ******************************************************
   // DMA request and underrun interrupt
   // ******************************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dma_req_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         dma_req_ff <= ch1_dma_on && trig_load1;
         irq_ff <= ch1_underrun && ctrl_ff[`DDC_CH1_UDRIE_BIT];
      end
   end

   // ******************************************************
   // Read data
   // ******************************************************
   always_comb begin
      prdata = 32'h00000000;
      if (psel && !pwrite) begin
         unique case (paddr)
            `DDC_OFS_CTRL: prdata = ctrl_ff;
            `DDC_OFS_SWTRIG: prdata = {30'h0, soft_fire_ff};
            `DDC_OFS_CH1_R12: prdata = {20'h0, ch1_hold_value_ff};
            `DDC_OFS_CH1_L12: prdata = {16'h0, ch1_hold_value_ff, 4'h0};
            `DDC_OFS_CH1_R8: prdata = {24'h0, ch1_hold_value_ff[11:4]};
            `DDC_OFS_CH2_R12: prdata = {20'h0, ch2_hold_value_ff};
            `DDC_OFS_CH1_OUT: prdata = {20'h0, ch1_out_ff};
            `DDC_OFS_CH2_OUT: prdata = {20'h0, ch2_out_ff};
            default: prdata = 32'h00000000;
         endcase
      end
   end

endmodule : ddc_top

/* File: hw/ddc_wave_gen.sv */
// Noise and triangle offset generator for channel one
`timescale 1ns/100ps

module ddc_wave_gen
   import ddc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] wave_select,
   input wire logic [3:0] mask_amplitude,
   input wire logic step,
   output ddc_sample_t offset
);

   ddc_sample_t lfsr_ff;
   ddc_sample_t tri_ff;
   logic tri_down_ff;
   ddc_sample_t limit;
   logic feedback;

   assign limit = ddc_mask(mask_amplitude);
   assign feedback = lfsr_ff[11] ^ lfsr_ff[5] ^ lfsr_ff[3] ^ lfsr_ff[0];

   // ******************************************************
   // Offset selection
   // ******************************************************
   always_comb begin
      unique case (wave_select)
         2'b00: offset = 12'h000;
         2'b01: offset = lfsr_ff & limit;
         default: offset = tri_ff;
      endcase
   end

   // ******************************************************
   // Noise register
   // ******************************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lfsr_ff <= `DDC_LFSR_SEED;
      end else if (step && wave_select == 2'b01) begin
         lfsr_ff <= {lfsr_ff[10:0], feedback};
      end
   end

   // ******************************************************
   // Triangle counter
   // ******************************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tri_ff <= 12'h000;
         tri_down_ff <= 1'b0;
      end else if (step && wave_select[1]) begin
         // Peak may shrink under the counter; turn down at once then
         if (!tri_down_ff && tri_ff >= limit) begin
            tri_down_ff <= 1'b1;
            tri_ff <= tri_ff - 12'h001;
         end else if (tri_down_ff && tri_ff == 12'h000) begin
            tri_down_ff <= 1'b0;
            tri_ff <= 12'h001;
         end else if (tri_down_ff) begin
            tri_ff <= tri_ff - 12'h001;
         end else begin
            tri_ff <= tri_ff + 12'h001;
         end
      end
   end

endmodule : ddc_wave_gen
